//--- rtl/iam_counters.sv
// Purpose: per-id occupancy and io bandwidth telemetry register bank
// Assumes: reads are one-cycle strobes with a byte address; data next cycle
// Notes:   bandwidth counters are fed by increment strobes, occupancy by value loads, from the monitoring fabric
//
// Contract
// R1: occupancy bit 63 is 0 when the id is monitored, 1 otherwise.
// R2: occupancy bits 62:0 are a read-only occupancy count, reset zero.
// R3: occupancy entry at base + id/clump*4096 + offset + id%clump*8.
// R4: occupancy entries never reach base plus block count times 4096.
// R5: software uses this indexing only when the version reads 1.
// R6: total bandwidth bit 63 is 1 when the id is unmonitored.
// R7: total bandwidth bit 62 flags overflow and clears on read.
// R8: total bandwidth bits 61:0 are a read-only count, reset zero.
// R9: total bandwidth entry placed by the clump formula with its offset.
// R10: total bandwidth entries lie below base plus block count times 4096.
// R11: ids run from zero to the maximum id, one domain only.
// R12: a per-id miss bandwidth entry is also provided from that base.
// R13: miss entry: bit 63 unavailable, bit 62 read-clear overflow, 61:0 count.
// R14: miss entries use the same formula with their own offset and clump.
// R15: overflow is sticky; a wrap during the clearing read survives.
`timescale 1ns/1ns
module iam_counters
    import iam_pkg::*;
#(
    parameter int unsigned NUM_IDS     = 16,
    parameter int unsigned ID_W        = 4,
    parameter logic [31:0] BASE_ADDR   = IAM_BASE_DFLT,
    parameter logic [31:0] OCC_OFF     = IAM_OCC_OFF_DFLT,
    parameter logic [31:0] TOT_OFF     = IAM_TOT_OFF_DFLT,
    parameter logic [31:0] MISS_OFF    = IAM_MISS_OFF_DFLT,
    parameter int unsigned OCC_CLUMP   = IAM_CLUMP_DFLT,
    parameter int unsigned TOT_CLUMP   = IAM_CLUMP_DFLT,
    parameter int unsigned MISS_CLUMP  = IAM_CLUMP_DFLT,
    parameter int unsigned BLOCK_COUNT = IAM_BLOCKS_DFLT
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  rd_en,
    input  wire logic [IAM_ADDR_W-1:0] rd_addr,
    output logic [63:0]                rd_data,
    output logic                       rd_valid,
    output logic                       rd_err,
    output logic [7:0]                 index_version,
    input  wire logic [NUM_IDS-1:0]    id_monitored,
    input  wire logic                  occ_upd,
    input  wire logic [ID_W-1:0]       occ_id,
    input  wire logic [IAM_OCC_W-1:0]  occ_value,
    input  wire logic                  tot_inc,
    input  wire logic [ID_W-1:0]       tot_id,
    input  wire logic [15:0]           tot_bytes,
    input  wire logic                  miss_inc,
    input  wire logic [ID_W-1:0]       miss_id,
    input  wire logic [15:0]           miss_bytes
);
    // ==========================================================================
    // state
    typedef struct packed {
        logic [NUM_IDS-1:0][IAM_OCC_W-1:0] occ;
        logic [NUM_IDS-1:0][IAM_BW_W-1:0]  tot;
        logic [NUM_IDS-1:0][IAM_BW_W-1:0]  miss;
        logic [NUM_IDS-1:0]                tot_ovf;
        logic [NUM_IDS-1:0]                miss_ovf;
        logic [63:0]                       rd_data;
        logic                              rd_valid;
        logic                              rd_err;
        logic [7:0]                        ver;
    } iam_state_t;

    iam_state_t st_r;
    iam_state_t st_nxt;

    // byte address of an entry by the clump formula
    function automatic logic [31:0] iam_entry_addr(input logic [31:0] id,
                                                   input logic [31:0] clump,
                                                   input logic [31:0] off);
        iam_entry_addr = BASE_ADDR + (id / clump) * IAM_BLOCK_BYTES
                       + off + (id % clump) * IAM_ENTRY_BYTES; // R3 R9 R14
    endfunction

    localparam logic [31:0] TOP_ADDR = BASE_ADDR + BLOCK_COUNT * IAM_BLOCK_BYTES;

    // ==========================================================================
    // address decode: find kind and id of the addressed entry
    iam_kind_t         hit_kind;
    logic [ID_W-1:0]   hit_id;
    always_comb begin
        hit_kind = IAM_K_NONE;
        hit_id   = '0;
        if (rd_addr < TOP_ADDR && rd_addr >= BASE_ADDR) begin // R4 R10
            for (int i = 0; i < NUM_IDS; i++) begin // R11
                if (rd_addr == iam_entry_addr(i, OCC_CLUMP, OCC_OFF)) begin
                    hit_kind = IAM_K_OCC;
                    hit_id   = ID_W'(i);
                end else if (rd_addr == iam_entry_addr(i, TOT_CLUMP, TOT_OFF)) begin
                    hit_kind = IAM_K_TOT;
                    hit_id   = ID_W'(i);
                end else if (rd_addr == iam_entry_addr(i, MISS_CLUMP, MISS_OFF)) begin
                    hit_kind = IAM_K_MISS; // R12
                    hit_id   = ID_W'(i);
                end
            end
        end
    end

    // ==========================================================================
    // next state: counters, sticky overflow, read answer
    logic [IAM_BW_W:0] tot_sum;
    logic [IAM_BW_W:0] miss_sum;
    always_comb begin
        st_nxt          = st_r;
        st_nxt.rd_valid = 1'b0;
        st_nxt.rd_err   = 1'b0;
        st_nxt.ver      = IAM_INDEX_VER; // R5
        tot_sum         = {1'b0, st_r.tot[tot_id]} + {{(IAM_BW_W-15){1'b0}}, tot_bytes};
        miss_sum        = {1'b0, st_r.miss[miss_id]} + {{(IAM_BW_W-15){1'b0}}, miss_bytes};
        // read first, so an overflow in the same cycle sets again below
        if (rd_en) begin
            st_nxt.rd_valid = 1'b1;
            st_nxt.rd_data  = IAM_ENTRY_RST;
            case (hit_kind)
                IAM_K_OCC: begin
                    st_nxt.rd_data[IAM_UNAVAIL_BIT]  = ~id_monitored[hit_id]; // R1
                    st_nxt.rd_data[IAM_OCC_W-1:0]    = st_r.occ[hit_id]; // R2
                end
                IAM_K_TOT: begin
                    st_nxt.rd_data[IAM_UNAVAIL_BIT]  = ~id_monitored[hit_id]; // R6
                    st_nxt.rd_data[IAM_OVF_BIT]      = st_r.tot_ovf[hit_id]; // R7
                    st_nxt.rd_data[IAM_BW_W-1:0]     = st_r.tot[hit_id]; // R8
                    st_nxt.tot_ovf[hit_id]           = 1'b0; // R7
                end
                IAM_K_MISS: begin
                    st_nxt.rd_data[IAM_UNAVAIL_BIT]  = ~id_monitored[hit_id]; // R13
                    st_nxt.rd_data[IAM_OVF_BIT]      = st_r.miss_ovf[hit_id]; // R13
                    st_nxt.rd_data[IAM_BW_W-1:0]     = st_r.miss[hit_id]; // R13
                    st_nxt.miss_ovf[hit_id]          = 1'b0; // R13
                end
                default: begin
                    st_nxt.rd_err = 1'b1; // unmapped: zero data, error flag
                end
            endcase
        end
        // occupancy is a level loaded by the fabric
        if (occ_upd && id_monitored[occ_id]) begin
            st_nxt.occ[occ_id] = occ_value;
        end
        // bandwidth counters wrap and set sticky overflow (set beats clear)
        if (tot_inc && id_monitored[tot_id]) begin
            st_nxt.tot[tot_id] = tot_sum[IAM_BW_W-1:0];
            if (tot_sum[IAM_BW_W]) begin
                st_nxt.tot_ovf[tot_id] = 1'b1; // R15
            end
        end
        if (miss_inc && id_monitored[miss_id]) begin
            st_nxt.miss[miss_id] = miss_sum[IAM_BW_W-1:0];
            if (miss_sum[IAM_BW_W]) begin
                st_nxt.miss_ovf[miss_id] = 1'b1; // R15
            end
        end
    end

    // ==========================================================================
    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data       = st_r.rd_data;
    assign rd_valid      = st_r.rd_valid;
    assign rd_err        = st_r.rd_err;
    assign index_version = st_r.ver;
endmodule

//--- rtl/iam_pkg.sv
// Purpose: constants shared by the io agent monitor counter bank
// Assumes: one clock, 64-bit register words, byte addresses
// Notes:   offsets and clump sizes are firmware-table values; defaults are plain
package iam_pkg;
    // ==========================================================================
    // address layout
    localparam int unsigned IAM_BLOCK_BYTES   = 4096;  // size of one register block
    localparam int unsigned IAM_ENTRY_BYTES   = 8;     // stride between ids in a clump
    localparam int unsigned IAM_ADDR_W        = 32;
    localparam logic [31:0] IAM_BASE_DFLT     = 32'h0000_0000;
    localparam logic [31:0] IAM_OCC_OFF_DFLT  = 32'h0000_0000;
    localparam logic [31:0] IAM_TOT_OFF_DFLT  = 32'h0000_0400;
    localparam logic [31:0] IAM_MISS_OFF_DFLT = 32'h0000_0800;
    localparam int unsigned IAM_CLUMP_DFLT    = 64;
    localparam int unsigned IAM_BLOCKS_DFLT   = 2;
    localparam logic [7:0]  IAM_INDEX_VER     = 8'h01; // indexing function version
    // ==========================================================================
    // entry fields
    localparam int unsigned IAM_UNAVAIL_BIT   = 63;
    localparam int unsigned IAM_OVF_BIT       = 62;
    localparam int unsigned IAM_OCC_W         = 63;
    localparam int unsigned IAM_BW_W          = 62;
    localparam logic [63:0] IAM_ENTRY_RST     = 64'h0;
    // ==========================================================================
    // entry kinds
    typedef enum logic [1:0] {
        IAM_K_OCC  = 2'b00,
        IAM_K_TOT  = 2'b01,
        IAM_K_MISS = 2'b10,
        IAM_K_NONE = 2'b11
    } iam_kind_t;
endpackage

//--- test/iam_counters_chk.sv
// Purpose: read-side checks on the counter bank ports
// Assumes: bound to every iam_counters instance
// Notes: count contents are judged by the bench
`timescale 1ns/1ns
module iam_chk
    import iam_pkg::*;
#(
    parameter logic [31:0] BASE_ADDR   = 32'h0,
    parameter logic [31:0] OCC_OFF     = 32'h0,
    parameter logic [31:0] TOT_OFF     = 32'h0,
    parameter int unsigned BLOCK_COUNT = 2,
    parameter int unsigned NUM_IDS     = 16
) (
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    input wire logic                  rd_en,
    input wire logic [IAM_ADDR_W-1:0] rd_addr,
    input wire logic [63:0]           rd_data,
    input wire logic                  rd_valid,
    input wire logic                  rd_err,
    input wire logic [7:0]            index_version,
    input wire logic [NUM_IDS-1:0]    id_monitored
);
    // ========================================================================
    // read answer, decode and flags
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] top_c;
    assign top_c = BASE_ADDR + 32'(BLOCK_COUNT * 4096); // first address past the bank
    a_answer_next: assert property (rd_en |=> rd_valid) else $error("read not answered");
    a_idle_quiet: assert property (!rd_en |=> !rd_valid && !rd_err) else $error("stray answer");
    a_err_zero: assert property (rd_err |-> rd_valid && rd_data == 64'h0) else $error("err data");
    a_range_refused: assert property (rd_en && (rd_addr >= top_c || rd_addr < BASE_ADDR)
        |=> rd_err) else $error("out of range accepted");
    a_unaligned_refused: assert property (rd_en && rd_addr[2:0] != 3'h0 |=> rd_err)
        else $error("unaligned accepted");
    a_occ_flag: assert property (rd_en && rd_addr == BASE_ADDR + OCC_OFF |=> !rd_err
        && rd_data[63] == !$past(id_monitored[0])) else $error("occ flag");
    a_tot_flag: assert property (rd_en && rd_addr == BASE_ADDR + TOT_OFF |=> !rd_err
        && rd_data[63] == !$past(id_monitored[0])) else $error("tot flag");
    a_version_one: assert property ($past(rst_n) |-> index_version == 8'h01)
        else $error("index version");
    c_refused: cover property (rd_err);
    c_unavail: cover property (rd_valid && rd_data[63]);
    c_counted: cover property (rd_valid && !rd_err && rd_data[61:0] != 62'h0);
endmodule
bind iam_counters iam_chk #(.BASE_ADDR(BASE_ADDR), .OCC_OFF(OCC_OFF), .TOT_OFF(TOT_OFF),
    .BLOCK_COUNT(BLOCK_COUNT), .NUM_IDS(NUM_IDS)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_err(rd_err), .index_version(index_version), .id_monitored(id_monitored));

//--- test/tb.sv
// Purpose: self-checking bench for the counter bank
// Assumes: small clumps so occupancy and total ids spread over several blocks; miss clump 16 keeps all 16 miss ids in one block
// Notes: entries predicted by an array model
`timescale 1ns/1ns
module tb;
    import iam_pkg::*;
    localparam int unsigned OC = 4, TC = 8, MC = 16, BC = 4;
    logic sys_clk = 0, rst_n = 0, rd_en = 0, occ_upd = 0, tot_inc = 0, miss_inc = 0;
    logic [31:0] rd_addr = 0;
    logic [63:0] rd_data;
    logic rd_valid, rd_err;
    logic [7:0] index_version;
    logic [15:0] id_monitored = 0, tot_bytes = 0, miss_bytes = 0;
    logic [3:0] occ_id = 0, tot_id = 0, miss_id = 0;
    logic [62:0] occ_value = 0, m_occ [16];
    logic [61:0] m_tot [16], m_miss [16];
    int err_total = 0, n_tests = 0, cyc = 0;
    // ========================================================================
    // clock, design and helpers
    always #5 sys_clk = ~sys_clk;
    iam_counters #(.OCC_CLUMP(OC), .TOT_CLUMP(TC), .MISS_CLUMP(MC), .BLOCK_COUNT(BC)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_err(rd_err), .index_version(index_version),
        .id_monitored(id_monitored), .occ_upd(occ_upd), .occ_id(occ_id), .occ_value(occ_value),
        .tot_inc(tot_inc), .tot_id(tot_id), .tot_bytes(tot_bytes), .miss_inc(miss_inc),
        .miss_id(miss_id), .miss_bytes(miss_bytes));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (err_total == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one read: request held for one edge, answer looked at the next cycle
    task automatic rd(input logic [31:0] a, input logic [63:0] e, input logic er,
                      input logic [63:0] mk);
        @(posedge sys_clk);
        #1 rd_en = 1'b1;
        rd_addr = a;
        @(posedge sys_clk);
        #1 rd_en = 1'b0;
        check({63'h0, rd_valid}, 64'h1);
        check({63'h0, rd_err}, {63'h0, er});
        check(rd_data & mk, e & mk);
    endtask
    task automatic rd_id(input int k, input int id);
        int cl;
        logic [31:0] off;
        cl = k == 0 ? OC : k == 1 ? TC : MC;
        off = k == 0 ? IAM_OCC_OFF_DFLT : k == 1 ? IAM_TOT_OFF_DFLT : IAM_MISS_OFF_DFLT;
        rd(IAM_BASE_DFLT + 32'(id / cl * 4096) + off + 32'(id % cl * 8),
           {~id_monitored[id], k == 0 ? m_occ[id] : {1'b0, k == 1 ? m_tot[id] : m_miss[id]}},
           1'b0, id_monitored[id] ? ~64'h0 : 64'h8000_0000_0000_0000);
    endtask
    // one counter update strobe; unmonitored ids leave the model alone
    task automatic upd(input int k, input int id, input logic [62:0] v);
        @(posedge sys_clk);
        #1 {occ_upd, tot_inc, miss_inc} = 3'h4 >> k;
        {occ_id, tot_id, miss_id} = {3{4'(id)}};
        {occ_value, tot_bytes, miss_bytes} = {v, v[15:0], v[15:0]};
        @(posedge sys_clk);
        #1 {occ_upd, tot_inc, miss_inc} = 3'h0;
        if (id_monitored[id] && k == 0) m_occ[id] = v;
        if (id_monitored[id] && k == 1) m_tot[id] += 62'(v[15:0]);
        if (id_monitored[id] && k == 2) m_miss[id] += 62'(v[15:0]);
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end
    // ========================================================================
    // main sequence: reset view, random updates, monitor flip, refusals
    initial begin
        void'($urandom(11507));
        for (int i = 0; i < 16; i++) {m_occ[i], m_tot[i], m_miss[i]} = 187'h0;
        id_monitored = (16'($urandom) | 16'h0001) & 16'hfffd;
        repeat (12) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        @(posedge sys_clk);
        #1 check({56'h0, index_version}, 64'h1);
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 3; k++) begin
                for (int id = 0; id < 16; id++) rd_id(k, id);
            end
            if (p == 0) begin
                for (int i = 0; i < 60; i++) upd($urandom % 3, $urandom % 16, 63'({$urandom, $urandom}));
            end
            if (p == 1) id_monitored = ~id_monitored;
        end
        rd(IAM_BASE_DFLT + 32'(BC * 4096), 64'h0, 1'b1, ~64'h0);
        rd(IAM_BASE_DFLT + 32'(OC * 8), 64'h0, 1'b1, ~64'h0);
        rd(IAM_BASE_DFLT + 32'(2 * 4096) + IAM_TOT_OFF_DFLT, 64'h0, 1'b1, ~64'h0);
        rd(IAM_BASE_DFLT + IAM_TOT_OFF_DFLT + 32'h4, 64'h0, 1'b1, ~64'h0);
        stop_test();
    end
endmodule
